/* File: rtl/wdt_cfg.svh */
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define WDT_ADDR_CONTROL 12'h034
`define WDT_ADDR_CODE 12'h038
`define WDT_ADDR_CONFIG 12'h03c
`define WDT_ADDR_STATUS 12'h040
`define WDT_ADDR_MASK 12'h044
`define WDT_ADDR_STATE 12'h048

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define WDT_CTL_RUN_BIT 3
`define WDT_CTL_PERIOD_HI 2
`define WDT_CTL_PERIOD_LO 1
`define WDT_CTL_ACTION_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WDT_RST_RUN 1'b1
`define WDT_RST_PERIOD 2'b00
`define WDT_RST_ACTION 1'b1
`define WDT_RST_TAP 1'b0
`define WDT_RST_MASK 2'b00

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define WDT_EV_IRQ 0
`define WDT_EV_RESET 1
`define WDT_EV_W 2

// ----------------------------------------------------------------
// Period exponents for period code 11; each lower code adds two
// ----------------------------------------------------------------
`define WDT_FC_EXP_BASE 19
`define WDT_FS_EXP_BASE 11
`define WDT_STAGE_BITS 2

`endif

/* File: rtl/wdt_pkg.sv */
package wdt_pkg;

    // Codes accepted by the code port
    typedef enum logic [7:0] {
        WDT_CODE_CLEAR = 8'h4e,
        WDT_CODE_DISABLE = 8'hb1
    } wdt_code_type;

    // Source of the divider count
    typedef enum logic [0:0] {
        WDT_SRC_FAST = 1'b0,
        WDT_SRC_SLOW = 1'b1
    } wdt_src_type;

endpackage

/* File: rtl/wdt_divider.sv */
`timescale 1ns/100ps
`default_nettype none
// Free-running prescaler; pulses once per 2**tapExp source ticks
module wdt_divider
    import wdt_pkg::*;
#(
    parameter int DivWidth = 29
) (
    input wire logic clk,
    input wire logic rstSyncN,
    input wire logic clear,
    input wire logic step,
    input wire logic [4:0] tapExp,
    output logic stageTick
);

    logic [DivWidth-1:0] divCount_r;
    logic [DivWidth-1:0] tapMask;

    // Low bits below the tap all ones means the tap carries next step
    assign tapMask = DivWidth'((64'h1 << tapExp) - 64'h1);
    assign stageTick = step && ((divCount_r & tapMask) == tapMask);

    // Divider runs on; only a disable clears it
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            divCount_r <= '0;
        end else if (clear) begin
            divCount_r <= '0;
        end else if (step) begin
            divCount_r <= divCount_r + DivWidth'(1);
        end
    end

endmodule
`default_nettype wire

/* File: rtl/wdt_stage_counter.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
// Two-stage binary counter; pulses once on overflow
module wdt_stage_counter
    import wdt_pkg::*;
(
    input wire logic clk,
    input wire logic rstSyncN,
    input wire logic clear,
    input wire logic tick,
    output logic overflow
);

    logic [`WDT_STAGE_BITS-1:0] stage_r;

    assign overflow = tick && (&stage_r);

    // Clear code and disable both empty the stages
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            stage_r <= '0;
        end else if (clear) begin
            stage_r <= '0;
        end else if (tick) begin
            stage_r <= stage_r + `WDT_STAGE_BITS'(1);
        end
    end

endmodule
`default_nettype wire

/* File: rtl/wdt_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_cfg.svh"
module wdt_top
    import wdt_pkg::*;
#(
    parameter int FcExpBase = `WDT_FC_EXP_BASE,
    parameter int FsExpBase = `WDT_FS_EXP_BASE
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic slowClkPin,
    input wire logic stopMode,
    input wire logic idleMode,
    input wire logic sleepMode,
    input wire logic slowMode,
    output logic wdogIrq,
    output logic wdogResetReq,
    output logic irq
);

    localparam int DivWidth = FcExpBase + 6;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic [1:0] rstPipe_r;
    logic rstSyncN;

    // Asynchronous assert, two-flop release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end
    assign rstSyncN = rstPipe_r[1];

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pinMeta_r;
    logic [4:0] pinSync_r;
    logic slowClkLast_r;
    logic slowEdge;
    logic holdCount;
    logic slowSel;

    // Two flops per pin before any logic reads it
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pinMeta_r <= 5'h00;
            pinSync_r <= 5'h00;
        end else begin
            pinMeta_r <= {slowMode, sleepMode, idleMode, stopMode, slowClkPin};
            pinSync_r <= pinMeta_r;
        end
    end

    // Rising edge of the synchronised low-frequency clock
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            slowClkLast_r <= 1'b0;
        end else begin
            slowClkLast_r <= pinSync_r[0];
        end
    end
    assign slowEdge = pinSync_r[0] && !slowClkLast_r;
    assign holdCount = pinSync_r[1] || pinSync_r[2] || pinSync_r[3];

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic runBit_r;
    logic [1:0] periodSel_r;
    logic actionSel_r;
    logic actionLock_r;
    logic active_r;
    logic tapSel_r;
    logic [`WDT_EV_W-1:0] status_r;
    logic [`WDT_EV_W-1:0] mask_r;
    logic setupPhase;
    logic accessDone;
    logic wrDone;
    logic rdDone;
    logic addrHit;
    logic codeClear;
    logic codeDisable;
    logic [31:0] readMux;
    logic [`WDT_EV_W-1:0] readTaken_r;

    // Address decode, used only for the setup-phase error answer
    function automatic logic isMapped(input logic [11:0] a);
        isMapped = (a == `WDT_ADDR_CONTROL) || (a == `WDT_ADDR_CODE) ||
                   (a == `WDT_ADDR_CONFIG) || (a == `WDT_ADDR_STATUS) ||
                   (a == `WDT_ADDR_MASK) || (a == `WDT_ADDR_STATE);
    endfunction

    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign wrDone = accessDone && pwrite && !pslverr;
    assign rdDone = accessDone && !pwrite && !pslverr;
    assign addrHit = isMapped(paddr);
    assign codeClear = wrDone && (paddr == `WDT_ADDR_CODE) &&
                       (pwdata[7:0] == WDT_CODE_CLEAR);
    assign codeDisable = wrDone && (paddr == `WDT_ADDR_CODE) &&
                         (pwdata[7:0] == WDT_CODE_DISABLE);

    // Control register fields
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            runBit_r <= `WDT_RST_RUN;
            periodSel_r <= `WDT_RST_PERIOD;
        end else if (wrDone && paddr == `WDT_ADDR_CONTROL) begin
            runBit_r <= pwdata[`WDT_CTL_RUN_BIT];
            periodSel_r <= pwdata[`WDT_CTL_PERIOD_HI:`WDT_CTL_PERIOD_LO];
        end
    end

    // Overflow action: reset after release, locked once cleared
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            actionSel_r <= `WDT_RST_ACTION;
            actionLock_r <= 1'b0;
        end else if (wrDone && paddr == `WDT_ADDR_CONTROL &&
                     !actionLock_r) begin
            actionSel_r <= pwdata[`WDT_CTL_ACTION_BIT];
            actionLock_r <= !pwdata[`WDT_CTL_ACTION_BIT];
        end
    end

    // Watchdog running state
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            active_r <= 1'b1;
        end else if (wrDone && paddr == `WDT_ADDR_CONTROL &&
                     pwdata[`WDT_CTL_RUN_BIT]) begin
            active_r <= 1'b1;
        end else if (codeDisable && !runBit_r) begin
            active_r <= 1'b0;
        end
    end

    // Prescale tap select
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            tapSel_r <= `WDT_RST_TAP;
        end else if (wrDone && paddr == `WDT_ADDR_CONFIG) begin
            tapSel_r <= pwdata[0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            mask_r <= `WDT_RST_MASK;
        end else if (wrDone && paddr == `WDT_ADDR_MASK) begin
            mask_r <= pwdata[`WDT_EV_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Counting chain
    // ----------------------------------------------------------------
    logic step;
    logic [4:0] tapExp;
    logic stageTick;
    logic overflow;

    assign slowSel = tapSel_r || pinSync_r[4];
    // Source tick, paused in stop, idle and sleep modes
    assign step = active_r && !holdCount &&
                  (slowSel ? slowEdge : 1'b1);
    // Divider tap two bits below the full period
    assign tapExp = slowSel ?
        5'(FsExpBase + 2 * (3 - int'(periodSel_r)) - `WDT_STAGE_BITS) :
        5'(FcExpBase + 2 * (3 - int'(periodSel_r)) - `WDT_STAGE_BITS);

    wdt_divider #(
        .DivWidth(DivWidth)
    ) uDivider (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .clear(!active_r),
        .step(step),
        .tapExp(tapExp),
        .stageTick(stageTick)
    );

    wdt_stage_counter uStages (
        .clk(clk),
        .rstSyncN(rstSyncN),
        .clear(!active_r || codeClear),
        .tick(stageTick),
        .overflow(overflow)
    );

    // ----------------------------------------------------------------
    // Overflow outputs
    // ----------------------------------------------------------------
    logic [`WDT_EV_W-1:0] events;

    assign events[`WDT_EV_IRQ] = overflow && !actionSel_r;
    assign events[`WDT_EV_RESET] = overflow && actionSel_r;

    // One-cycle pulses on the chosen path
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wdogIrq <= 1'b0;
            wdogResetReq <= 1'b0;
        end else begin
            wdogIrq <= events[`WDT_EV_IRQ];
            wdogResetReq <= events[`WDT_EV_RESET];
        end
    end

    // Sticky status; a new event beats the read clear
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            status_r <= '0;
        end else if (rdDone && paddr == `WDT_ADDR_STATUS) begin
            status_r <= (status_r & ~readTaken_r) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    // Level interrupt from unmasked status
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // APB answer
    // ----------------------------------------------------------------
    // Read data; control and code port read as zero
    always_comb begin
        readMux = 32'h0000_0000;
        unique case (paddr)
            `WDT_ADDR_CONFIG: readMux = {31'h0, tapSel_r};
            `WDT_ADDR_STATUS: readMux = {30'h0, status_r};
            `WDT_ADDR_MASK: readMux = {30'h0, mask_r};
            `WDT_ADDR_STATE: readMux = {26'h0, actionLock_r,
                                        active_r, runBit_r, periodSel_r,
                                        actionSel_r};
            default: readMux = 32'h0000_0000;
        endcase
    end

    // Answer prepared in setup, shown for the single access cycle
    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            readTaken_r <= '0;
        end else if (setupPhase) begin
            pready <= 1'b1;
            pslverr <= !addrHit;
            prdata <= pwrite ? 32'h0000_0000 : readMux;
            readTaken_r <= status_r;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

/* File: tb/wdt_chk_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker for the watchdog
// ----------------------------------------
module wdt_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic stopMode,
    input wire logic idleMode,
    input wire logic sleepMode,
    input wire logic wdogIrq,
    input wire logic wdogResetReq
);
    logic xfer, runR, onR, actR, lockR, ov;
    assign xfer = psel && penable && pready;
    assign ov = wdogIrq || wdogResetReq;
    // Shadow of run, active, action and lock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            runR <= 1'b1;
            onR <= 1'b1;
            actR <= 1'b1;
            lockR <= 1'b0;
        end else if (xfer && pwrite && paddr == 12'h034) begin
            runR <= pwdata[3];
            onR <= onR | pwdata[3];
            actR <= actR & pwdata[0];
            lockR <= lockR | ~pwdata[0];
        end else if (xfer && pwrite && paddr == 12'h038 &&
                     pwdata[7:0] == 8'hb1 && !runR) begin
            onR <= 1'b0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_state_read: assert property (xfer && !pwrite && paddr == 12'h048
        |-> {prdata[5:3], prdata[0]} == {lockR, onR, runR, actR})
        else $error("state read differs from control shadow");
    a_ctl_read: assert property (xfer && !pwrite && paddr == 12'h034
        |-> prdata == 32'h0) else $error("control read not zero");
    a_irq_pulse: assert property (wdogIrq |=> !wdogIrq)
        else $error("interrupt pulse too long");
    a_rst_pulse: assert property (wdogResetReq |=> !wdogResetReq)
        else $error("reset request pulse too long");
    a_route_reset: assert property (wdogResetReq |-> $past(actR))
        else $error("reset request with action interrupt");
    a_route_irq: assert property (wdogIrq |-> !$past(actR))
        else $error("interrupt with action reset");
    a_pause_quiet: assert property ((stopMode || idleMode || sleepMode)
        [*6] |-> !ov) else $error("overflow while paused");
    a_off_quiet: assert property (!onR [*4] |-> !ov)
        else $error("overflow while disabled");
endmodule
bind wdt_top wdt_chk u_chk (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .stopMode, .idleMode, .sleepMode,
    .wdogIrq, .wdogResetReq);
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk, resetn, psel, penable, pwrite, slowMode, slowClk, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] pause;
    logic [1:0] sdiv;
    logic pready, pslverr, wdogIrq, wdogResetReq, irq;
    int err_total, n_checks, cyc, nPulse, n, p0;
    // Clock, 25 ns period
    always #12.5 clk = ~clk;
    wdt_top #(.FcExpBase(3), .FsExpBase(3)) DUT (.clk, .resetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .slowClkPin(slowClk), .stopMode(pause[0]), .idleMode(pause[1]),
        .sleepMode(pause[2]), .slowMode, .wdogIrq, .wdogResetReq, .irq);
    // Slow clock at a quarter rate, pulse count and hang limit
    assign slowClk = sdiv[1];
    always @(posedge clk) begin
        sdiv <= sdiv + 2'h1;
        cyc <= cyc + 1;
        if (wdogIrq || wdogResetReq)
            nPulse <= nPulse + 1;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One APB transfer; waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    // Cycles until the next overflow pulse
    task ov;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wdogIrq !== 1'b1 && wdogResetReq !== 1'b1 && n < 3000);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {clk, psel, penable, pwrite, slowMode, resetn, paddr} = '0;
        {pwdata, pause, sdiv, err_total, n_checks, cyc, nPulse} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(12'h048, 32'h19, "state");
        rd(12'h034, 32'h0, "control");
        apb(1'b0, 12'h100, 32'h0);
        chk("slverr", {31'h0, perr}, 32'h1);
        apb(1'b1, 12'h044, 32'h3);
        ov;
        chk("rstreq", {30'h0, wdogResetReq, wdogIrq}, 32'h2);
        @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(12'h040, 32'h2, "status");
        rd(12'h040, 32'h0, "status");
        apb(1'b1, 12'h034, 32'h8);
        apb(1'b1, 12'h034, 32'h9);
        rd(12'h048, 32'h38, "locked");
        apb(1'b1, 12'h044, 32'h2);
        ov;
        chk("irqreq", {30'h0, wdogResetReq, wdogIrq}, 32'h1);
        repeat (2) @(posedge clk);
        chk("masked", {31'h0, irq}, 32'h0);
        rd(12'h040, 32'h1, "status");
        p0 = nPulse;
        repeat (4) begin
            repeat (300) @(posedge clk);
            apb(1'b1, 12'h038, 32'h4e);
        end
        chk("quiet", nPulse, p0);
        ov;
        chk("cleared", {31'h0, n >= 380 && n <= 515}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 12'h038, 32'h4e);
            repeat (200) @(posedge clk);
            p0 = nPulse;
            pause <= 3'h1 << i;
            repeat (600) @(posedge clk);
            chk("paused", nPulse, p0);
            pause <= 3'h0;
            ov;
            chk("resume", {31'h0, n <= 330}, 32'h1);
        end
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h034, {28'h0, 1'b1, c[1:0], 1'b0});
            ov;
            ov;
            chk("period", n, 32'h1 << (9 - 2 * c));
        end
        for (int j = 0; j < 2; j++) begin
            slowMode <= (j == 0);
            apb(1'b1, 12'h03c, j);
            for (int c = 2; c < 4; c++) begin
                apb(1'b1, 12'h034, {28'h0, 1'b1, c[1:0], 1'b0});
                ov;
                ov;
                chk("slow", n, 32'h4 << (9 - 2 * c));
            end
        end
        apb(1'b1, 12'h03c, 32'h0);
        apb(1'b1, 12'h034, 32'h8);
        apb(1'b1, 12'h038, 32'hb1);
        rd(12'h048, 32'h38, "on");
        apb(1'b1, 12'h038, 32'h4e);
        apb(1'b1, 12'h034, 32'h0);
        apb(1'b1, 12'h038, 32'h55);
        rd(12'h048, 32'h30, "on");
        apb(1'b1, 12'h038, 32'hb1);
        rd(12'h048, 32'h20, "off");
        p0 = nPulse;
        repeat (1200) @(posedge clk);
        chk("off", nPulse, p0);
        apb(1'b1, 12'h034, 32'h8);
        ov;
        chk("restart", {31'h0, n >= 505 && n <= 516}, 32'h1);
        resetn <= 1'b0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd(12'h048, 32'h19, "rerun");
        give_verdict();
    end
endmodule
`default_nettype wire
